// ===== bench/crt_ctrl_properties.sv
module crt_ctrl_chk (
   input logic        clk,
   input logic        rst,
   input logic [7:0]  reg_addr,
   input logic [7:0]  reg_wdata,
   input logic        reg_wr,
   input logic [7:0]  reg_rdata_r,
   input logic [2:0]  charge_stage_code,
   input logic        charger_logic_active,
   input logic        solar_powered,
   input logic        temp_comp_enable,
   input logic        supply_stage3_permit,
   input logic        solar_stage3_permit,
   input logic [15:0] vbat_mv,
   input logic [15:0] vs2_nominal_mv,
   input logic [15:0] vs2_comp_mv,
   input logic [3:0]  stage_timer_expired,
   input logic        in_done_stage,
   input logic [15:0] done_restart_voltage_r,
   input logic        restart_done_volt_r,
   input logic        restart_done_timer_r,
   input logic        restart_stage3_r,
   input logic        terminate_done_r,
   input logic        goto_stage3_r,
   input logic [3:0]  timer_fault_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0]  c47, c48, c49, c4a, rd_exp;
   logic [6:0]  pct;
   logic [22:0] lvl;
   // ************************************************
   // Shadow of the configuration seen on the write port
   // ************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {c47, c48, c49, c4a} <= 32'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            8'h47: c47 <= reg_wdata;
            8'h48: c48 <= reg_wdata & 8'h3F;
            8'h49: c49 <= reg_wdata & 8'h01;
            8'h4A: c4a <= reg_wdata & 8'h3F;
            default: ;
         endcase
      end
   end
   always_comb begin
      case (reg_addr)
         8'h47: rd_exp = c47;
         8'h48: rd_exp = c48;
         8'h49: rd_exp = c49;
         8'h4A: rd_exp = c4a;
         default: rd_exp = 8'h00;
      endcase
   end
   assign pct = (c47[6:0] > 7'h63) ? 7'h63 : c47[6:0];
   assign lvl = 23'(temp_comp_enable ? vs2_comp_mv : vs2_nominal_mv) * 23'(pct) / 23'h64;
   sequence s_volt_low;
      c47[7] && in_done_stage && vbat_mv < done_restart_voltage_r;
   endsequence
   sequence s_tmr_hit;
      (stage_timer_expired & (4'h1 << charge_stage_code)) != 4'h0 && !solar_powered && charger_logic_active;
   endsequence
   AST_DONE_DECODE: assert property (in_done_stage == (charger_logic_active && charge_stage_code == 3'h4))
      else $error("done stage decode wrong");
   AST_LEVEL: assert property (done_restart_voltage_r == $past(lvl[15:0]))
      else $error("restart level wrong");
   AST_READBACK: assert property (reg_rdata_r == $past(rd_exp))
      else $error("read data wrong");
   AST_VOLT_RESTART: assert property (
      restart_done_volt_r |-> $past(c47[7] && in_done_stage && vbat_mv < done_restart_voltage_r)
      ##1 !restart_done_volt_r)
      else $error("voltage restart without cause");
   AST_TIMED_RESTART: assert property (restart_done_timer_r |-> $past(in_done_stage) && c48[5:0] != 6'h0)
      else $error("timed restart without cause");
   AST_S3_RESTART: assert property (
      restart_stage3_r |-> $past(c49[0] && charge_stage_code == 3'h3) ##1 !restart_stage3_r)
      else $error("stage 3 restart without cause");
   AST_GOTO3: assert property (
      goto_stage3_r |-> $past(charge_stage_code == 3'h2 && (solar_powered ?
      solar_stage3_permit && c4a[4] : supply_stage3_permit && c4a[5])))
      else $error("stage 3 entry without cause");
   AST_TMR_DISPATCH: assert property (s_tmr_hit |=> (timer_fault_r != 4'h0) != terminate_done_r)
      else $error("timer expiry not dispatched");
   AST_FAULT_BITS: assert property (
      timer_fault_r != 4'h0 |-> !$past(solar_powered)
      && timer_fault_r == $past(stage_timer_expired & ~c4a[3:0] & (4'h1 << charge_stage_code)))
      else $error("timer fault bits wrong");
   AST_VOLT_SEEN: cover property (s_volt_low);
endmodule // crt_ctrl_chk

// ===== bench/crt_host_model.sv
module crt_host_model (
   input  logic       clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic       reg_wr,
   input  logic [7:0] reg_rdata_r
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // Released data shows garbage, not the last byte
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata_r;
   endtask
endmodule // crt_host_model

// ===== bench/test_charge_restart_termination_ctrl.sv
module test_charge_restart_termination_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [35:0] H = 36'hA;
   logic clk, rst, reg_wr, charger_logic_active, solar_powered, temp_comp_enable;
   logic supply_stage3_permit, solar_stage3_permit, in_done_stage, restart_done_volt_r;
   logic restart_done_timer_r, restart_stage3_r, terminate_done_r, goto_stage3_r;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_r, rd, a, m;
   logic [2:0] charge_stage_code;
   logic [3:0] stage_timer_expired, timer_fault_r;
   logic [5:0] evs;
   logic [15:0] vbat_mv, vs2_nominal_mv, vs2_comp_mv, vs3_mv, iout_ma, capacity_ma, done_restart_voltage_r;
   int n_mismatch = 0;
   int comparisons = 0;
   int ev[6];
   int n;
   crt_ctrl #(.HALFHOUR_CYCLES(H)) dut (.*);
   crt_host_model host (.*);
   assign evs = {restart_done_volt_r, restart_done_timer_r, restart_stage3_r,
      terminate_done_r, goto_stage3_r, |timer_fault_r};
   always @(posedge clk) begin
      foreach (ev[k]) ev[k] += evs[5 - k];
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge clk);
   endtask
   function automatic logic [15:0] lvl_of(input logic [6:0] p, input logic [15:0] v);
      logic [31:0] q;
      q = (p > 7'h63) ? 32'h63 : 32'(p);
      return 16'((q * v) / 32'h64);
   endfunction
   function automatic logic [7:0] mask_of(input logic [7:0] ad);
      return ad == 8'h47 ? 8'hFF : ad == 8'h49 ? 8'h01 : ad < 8'h4B ? 8'h3F : 8'h00;
   endfunction
   task automatic summarize;
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize;
   end
   initial begin
      {rst, charger_logic_active, solar_powered, temp_comp_enable} = 4'hC;
      {supply_stage3_permit, solar_stage3_permit, charge_stage_code, stage_timer_expired} = 9'h0;
      {vbat_mv, vs2_nominal_mv, vs2_comp_mv, vs3_mv} = {16'd13000, 16'd14200, 16'd14000, 16'd13500};
      {iout_ma, capacity_ma} = {16'd150, 16'd1000};
      void'($urandom(81));
      repeat (10) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      for (a = 8'h47; a < 8'h4D; a++) begin
         host.rd(a, rd);
         check(rd, 8'h00);
         m = 8'($urandom);
         host.wr(a, m);
         host.rd(a, rd);
         check(rd, m & mask_of(a));
         host.wr(a, 8'h00);
      end
      for (int k = 0; k < 6; k++) begin
         m = k < 3 ? 8'h63 + 8'(k * k * 14) : 8'($urandom % 128);
         {vs2_nominal_mv, vs2_comp_mv, temp_comp_enable} = 33'({$urandom, $urandom});
         charge_stage_code = 3'($urandom);
         charger_logic_active = 1'($urandom);
         host.wr(8'h47, m);
         tick(3);
         check(done_restart_voltage_r, lvl_of(m[6:0], temp_comp_enable ? vs2_comp_mv : vs2_nominal_mv));
         check(in_done_stage, charger_logic_active && charge_stage_code == 3'h4);
      end
      {charge_stage_code, charger_logic_active, temp_comp_enable, vs2_nominal_mv} = {3'h4, 2'h2, 16'd14200};
      // Threshold kept under the stage 3 level and above undervoltage
      host.wr(8'h47, 8'h55);
      vbat_mv = 16'd12000;
      ev = '{default: 0};
      tick(4);
      check(ev[0], 0);
      host.wr(8'h47, 8'hD5);
      tick(5);
      check(ev[0], 1);
      {vbat_mv, charge_stage_code} = {16'd13000, 3'h0};
      host.wr(8'h47, 8'h00);
      host.wr(8'h48, 8'h02);
      charge_stage_code = 3'h4;
      ev = '{default: 0};
      for (n = 0; n < 100 && ev[1] == 0; n++) tick(1);
      check(n >= 2 * H && n <= 2 * H + 4, 1);
      charge_stage_code = 3'h0;
      host.wr(8'h48, 8'h00);
      charge_stage_code = 3'h4;
      ev = '{default: 0};
      tick(4 * H);
      check(ev[1], 0);
      charge_stage_code = 3'h3;
      host.wr(8'h49, 8'h01);
      for (int k = 0; k < 4; k++) begin
         ev = '{default: 0};
         {iout_ma, vbat_mv} = k < 2 ? {16'd201 - 16'(k), 16'd13000} : {16'd150, 16'd12957 + 16'(k)};
         tick(4);
         check(ev[2], iout_ma * 5 > capacity_ma || vbat_mv * 100 < vs3_mv * 96);
         {iout_ma, vbat_mv} = {16'd150, 16'd13000};
         tick(2);
      end
      host.wr(8'h49, 8'h00);
      for (int k = 0; k < 8; k++) begin
         // Upper half sets only the other source's low-current bit
         host.wr(8'h4A, k[2] ? (k[1] ? 8'h20 : 8'h10) : 8'h30);
         {solar_powered, supply_stage3_permit, solar_stage3_permit} = {k[1], k[0], k[0]};
         ev = '{default: 0};
         {charge_stage_code, iout_ma} = {3'h2, 16'd99};
         tick(4);
         check(ev[3], !k[2] && !k[0]);
         check(ev[4], !k[2] && k[0]);
         check(ev[3] + ev[4], !k[2]);
         {charge_stage_code, iout_ma} = {3'h0, 16'd150};
         tick(2);
      end
      m = 8'($urandom);
      for (int p = 0; p < 2; p++) begin
         m = ~m & 8'h0F;
         host.wr(8'h4A, m);
         for (int i = 0; i < 8; i++) begin
            {solar_powered, charge_stage_code} = {i[2], 1'b0, i[1:0]};
            ev = '{default: 0};
            stage_timer_expired = 4'h1 << i[1:0];
            tick(1);
            stage_timer_expired = 4'h0;
            tick(3);
            check(ev[3], !i[2] && m[i[1:0]]);
            check(ev[5], !i[2] && !m[i[1:0]]);
         end
      end
      summarize;
   end
endmodule // test_charge_restart_termination_ctrl
bind crt_ctrl crt_ctrl_chk chk (.*);

// ===== shared/crt_consts.vh
`ifndef CRT_CONSTS_VH
`define CRT_CONSTS_VH

// ************************************************
// Register offsets
// ************************************************
`define CRT_ADDR_DONE_VOLT   8'h47
`define CRT_ADDR_DONE_DELAY  8'h48
`define CRT_ADDR_S3_RESTART  8'h49
`define CRT_ADDR_TERMINATE   8'h4A

// ************************************************
// Reset values
// ************************************************
`define CRT_RST_DONE_VOLT    8'h00
`define CRT_RST_DONE_DELAY   8'h00
`define CRT_RST_S3_RESTART   8'h00
`define CRT_RST_TERMINATE    8'h00

// ************************************************
// Field layouts
// ************************************************
`define CRT_DV_EN_BIT        7
`define CRT_DV_PCT_MSB       6
`define CRT_DD_HRS_MSB       5
`define CRT_S3_EN_BIT        0
`define CRT_TM_SUP_C10_BIT   5
`define CRT_TM_SOL_C10_BIT   4
`define CRT_TM_TMR_MSB       3
`define CRT_WMASK_DONE_VOLT  8'hFF
`define CRT_WMASK_DONE_DELAY 8'h3F
`define CRT_WMASK_S3_RESTART 8'h01
`define CRT_WMASK_TERMINATE  8'h3F

// ************************************************
// Stage codes
// ************************************************
`define CRT_STAGE_0          3'h0
`define CRT_STAGE_1          3'h1
`define CRT_STAGE_2          3'h2
`define CRT_STAGE_3          3'h3
`define CRT_STAGE_DONE       3'h4
`define CRT_NUM_STAGES       4

// ************************************************
// Arithmetic constants
// ************************************************
`define CRT_PCT_MAX          7'h63
`define CRT_PCT_SCALE        7'h64
`define CRT_S3_RESTART_PCT   7'h60
`define CRT_C5_DIV           3'h5
`define CRT_C10_DIV          4'hA

// ************************************************
// Timing
// ************************************************
`define CRT_CLK_HZ           36'd10000000
`define CRT_HALFHOUR_S       36'd1800
`define CRT_HALFHOUR_CYC     (`CRT_HALFHOUR_S * `CRT_CLK_HZ)

`endif

// ===== verilog/crt_ctrl.v
// What this block does
// R1: In done stage with enable set, restart when battery falls below restart level.
// R2: Threshold field is a seven-bit percent of Stage 2 voltage, capped at 99.
// R3: Done stage means stage code 100b with charger logic active.
// R4: Restart level follows temperature-compensated Stage 2 voltage when compensation enabled.
// R5: Software keeps threshold below Stage 3 voltage and 4% above undervoltage.
// R6: Non-zero delay field restarts in Stage 0 after that many half hours.
// R7: All-zero delay field disables the timed restart from done.
// R8: Stage 3 restart when current above C/5 or voltage below 96% of Stage 3.
// R9: On supply with bit set, Stage 2 current below C/10 ends charging.
// R10: On solar with bit set, Stage 2 current below C/10 ends charging.
// R11: Stage 3 permit for active source turns that termination into Stage 3 entry.
// R12: Timer expiry in a stage with term bit set ends charging, no fault.
// R13: Timer expiry in a stage with term bit clear raises a fault.
// R14: On solar power stage timers and timer termination are inactive.
// R15: Restart level is threshold over hundred times Stage 2 voltage, continuously updated.
`include "crt_consts.vh"

module crt_ctrl #(
   parameter [35:0] HALFHOUR_CYCLES = `CRT_HALFHOUR_CYC
) (
   input  wire        clk,
   input  wire        rst,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   output reg  [7:0]  reg_rdata_r,
   input  wire [2:0]  charge_stage_code,
   input  wire        charger_logic_active,
   input  wire        solar_powered,
   input  wire        temp_comp_enable,
   input  wire        supply_stage3_permit,
   input  wire        solar_stage3_permit,
   input  wire [15:0] vbat_mv,
   input  wire [15:0] vs2_nominal_mv,
   input  wire [15:0] vs2_comp_mv,
   input  wire [15:0] vs3_mv,
   input  wire [15:0] iout_ma,
   input  wire [15:0] capacity_ma,
   input  wire [3:0]  stage_timer_expired,
   output wire        in_done_stage,
   output reg  [15:0] done_restart_voltage_r,
   output reg         restart_done_volt_r,
   output reg         restart_done_timer_r,
   output reg         restart_stage3_r,
   output reg         terminate_done_r,
   output reg         goto_stage3_r,
   output reg  [3:0]  timer_fault_r
);

   // ************************************************
   // Stage decode
   // ************************************************
   function stage_is;
      input [2:0] code;
      input [2:0] stage;
      input       active;
      begin
         stage_is = active && (code == stage);
      end
   endfunction

   // ************************************************
   // Register address decode
   // ************************************************
   // One decode shared by writes and reads keeps both paths on the same map
   function [3:0] reg_sel;
      input [7:0] addr;
      begin
         case (addr)
            `CRT_ADDR_DONE_VOLT:  reg_sel = 4'h1;
            `CRT_ADDR_DONE_DELAY: reg_sel = 4'h2;
            `CRT_ADDR_S3_RESTART: reg_sel = 4'h4;
            `CRT_ADDR_TERMINATE:  reg_sel = 4'h8;
            default:              reg_sel = 4'h0;
         endcase
      end
   endfunction

   wire [3:0] sel;

   assign sel = reg_sel(reg_addr);

   // ************************************************
   // Configuration registers
   // ************************************************
   reg  [7:0] done_restart_voltage_cfg_r;
   reg  [7:0] done_restart_delay_cfg_r;
   reg  [7:0] stage3_restart_cfg_r;
   reg  [7:0] charge_termination_cfg_r;

   // Every restart and termination feature comes out of reset disabled
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         done_restart_voltage_cfg_r <= `CRT_RST_DONE_VOLT;
         done_restart_delay_cfg_r   <= `CRT_RST_DONE_DELAY;
         stage3_restart_cfg_r       <= `CRT_RST_S3_RESTART;
         charge_termination_cfg_r   <= `CRT_RST_TERMINATE;
      end else if (reg_wr) begin
         case (sel)
            4'h1: begin
               done_restart_voltage_cfg_r <= reg_wdata & `CRT_WMASK_DONE_VOLT;
            end
            4'h2: begin
               done_restart_delay_cfg_r <= reg_wdata & `CRT_WMASK_DONE_DELAY;
            end
            4'h4: begin
               stage3_restart_cfg_r <= reg_wdata & `CRT_WMASK_S3_RESTART;
            end
            4'h8: begin
               charge_termination_cfg_r <= reg_wdata & `CRT_WMASK_TERMINATE;
            end
            default: begin
            end
         endcase
      end
   end

   // Reserved bits are held at zero by the write masks; unmapped reads return zero
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else begin
         case (sel)
            4'h1:                  reg_rdata_r <= done_restart_voltage_cfg_r;
            4'h2:                  reg_rdata_r <= done_restart_delay_cfg_r;
            4'h4:                  reg_rdata_r <= stage3_restart_cfg_r;
            4'h8:                  reg_rdata_r <= charge_termination_cfg_r;
            default:               reg_rdata_r <= 8'h00;
         endcase
      end
   end

   // ************************************************
   // Field extraction
   // ************************************************
   wire       dv_enable;
   wire [6:0] dv_pct_raw;
   wire [6:0] dv_pct;
   wire [5:0] dd_halfhours;
   wire       s3_restart_en;
   wire       sup_c10_term;
   wire       sol_c10_term;
   wire [3:0] tmr_term_en;

   assign dv_enable     = done_restart_voltage_cfg_r[`CRT_DV_EN_BIT];
   assign dv_pct_raw    = done_restart_voltage_cfg_r[`CRT_DV_PCT_MSB:0];
   // R2: percent cap at 99
   assign dv_pct        = (dv_pct_raw > `CRT_PCT_MAX) ? `CRT_PCT_MAX : dv_pct_raw;
   assign dd_halfhours  = done_restart_delay_cfg_r[`CRT_DD_HRS_MSB:0];
   assign s3_restart_en = stage3_restart_cfg_r[`CRT_S3_EN_BIT];
   assign sup_c10_term  = charge_termination_cfg_r[`CRT_TM_SUP_C10_BIT];
   assign sol_c10_term  = charge_termination_cfg_r[`CRT_TM_SOL_C10_BIT];
   assign tmr_term_en   = charge_termination_cfg_r[`CRT_TM_TMR_MSB:0];

   // ************************************************
   // Stage state
   // ************************************************
   wire in_s2;
   wire in_s3;

   // R3: done stage decode
   assign in_done_stage = stage_is(charge_stage_code, `CRT_STAGE_DONE, charger_logic_active);
   assign in_s2         = stage_is(charge_stage_code, `CRT_STAGE_2, charger_logic_active);
   assign in_s3         = stage_is(charge_stage_code, `CRT_STAGE_3, charger_logic_active);

   // ************************************************
   // Done-restart level
   // ************************************************
   wire [15:0] vs2_eff;
   wire [22:0] level_prod;
   wire [22:0] level_quot;
   wire [22:0] vbat_x100;

   // R4: compensated Stage 2 voltage feeds the level
   assign vs2_eff    = temp_comp_enable ? vs2_comp_mv : vs2_nominal_mv;
   // R15: level = pct / 100 * Vs2
   assign level_prod = vs2_eff * dv_pct;
   assign level_quot = level_prod / {16'h0000, `CRT_PCT_SCALE};

   // Registered so the level is re-evaluated every cycle yet never glitches the compare
   always @(posedge clk or posedge rst) begin
      if (rst)
         done_restart_voltage_r <= 16'h0000;
      else
         done_restart_voltage_r <= level_quot[15:0];
   end

   assign vbat_x100 = vbat_mv * `CRT_PCT_SCALE;

   // ************************************************
   // Timed restart from done
   // ************************************************
   wire dd_expired;

   // Each visit to done starts a fresh delay, since the counter clears outside it
   // R6: half-hour delay counter
   crt_done_delay #(
      .HALFHOUR_CYCLES (HALFHOUR_CYCLES)
   ) u_delay (
      .clk             (clk),
      .rst             (rst),
      .run             (in_done_stage),
      .delay_halfhours (dd_halfhours),
      .expired_r       (dd_expired)
   );

   // ************************************************
   // Restart and termination conditions
   // ************************************************
   wire        cond_volt;
   wire        cond_timer;
   wire        cond_s3;
   wire [22:0] vs3_x96;
   wire [18:0] iout_x5;
   wire [19:0] iout_x10;
   wire        low_current;
   wire        c10_enabled;
   wire        s3_permit;
   wire        cond_c10;

   // R1: voltage restart in done
   assign cond_volt  = dv_enable && in_done_stage && (vbat_mv < done_restart_voltage_r);
   // R7: zero delay never expires
   assign cond_timer = in_done_stage && dd_expired;

   // Both sides of the 96% compare and the current side of each C/n compare are scaled up, so no division or rounding is needed
   assign vs3_x96 = vs3_mv * `CRT_S3_RESTART_PCT;
   assign iout_x5 = iout_ma * `CRT_C5_DIV;
   // R8: Stage 3 restart on C/5 or 96%
   assign cond_s3 = s3_restart_en && in_s3 &&
                    ((iout_x5 > {3'h0, capacity_ma}) || (vbat_x100 < vs3_x96));

   assign iout_x10    = iout_ma * `CRT_C10_DIV;
   assign low_current = iout_x10 < {4'h0, capacity_ma};
   // R9: supply C/10 enable; R10: solar C/10 enable
   assign c10_enabled = solar_powered ? sol_c10_term : sup_c10_term;
   assign s3_permit   = solar_powered ? solar_stage3_permit : supply_stage3_permit;
   assign cond_c10    = in_s2 && low_current && c10_enabled;

   // ************************************************
   // Stage timer expiry
   // ************************************************
   wire [3:0] tmr_term;
   wire [3:0] tmr_fault;

   genvar gi;
   generate
      // Expiry arrives as a one-cycle pulse, so no edge detector is needed here
      for (gi = 0; gi < `CRT_NUM_STAGES; gi = gi + 1) begin : g_tmr
         wire in_stage;
         assign in_stage = stage_is(charge_stage_code, gi[2:0], charger_logic_active);
         // R14: solar disables timers
         // R12: term bit ends charging
         assign tmr_term[gi]  = stage_timer_expired[gi] && in_stage && !solar_powered && tmr_term_en[gi];
         // R13: clear bit means fault
         assign tmr_fault[gi] = stage_timer_expired[gi] && in_stage && !solar_powered && !tmr_term_en[gi];
      end
   endgenerate

   // ************************************************
   // Event pulses
   // ************************************************
   reg volt_seen_r;
   reg timer_seen_r;
   reg s3_seen_r;
   reg c10_seen_r;

   // Level conditions produce one pulse on their rising edge so the stage
   // machine is not asked twice while it is still reacting
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         volt_seen_r          <= 1'b0;
         timer_seen_r         <= 1'b0;
         s3_seen_r            <= 1'b0;
         c10_seen_r           <= 1'b0;
         restart_done_volt_r  <= 1'b0;
         restart_done_timer_r <= 1'b0;
         restart_stage3_r     <= 1'b0;
         terminate_done_r     <= 1'b0;
         goto_stage3_r        <= 1'b0;
         timer_fault_r        <= 4'h0;
      end else begin
         volt_seen_r          <= cond_volt;
         timer_seen_r         <= cond_timer;
         s3_seen_r            <= cond_s3;
         c10_seen_r           <= cond_c10;
         // R1: voltage restart pulse
         restart_done_volt_r  <= cond_volt && !volt_seen_r;
         // A voltage restart in the same cycle wins and the timed one is dropped
         // R6: timed restart to Stage 0
         restart_done_timer_r <= cond_timer && !timer_seen_r && !(cond_volt && !volt_seen_r);
         // R8: Stage 3 restart pulse
         restart_stage3_r     <= cond_s3 && !s3_seen_r;
         // R11: permit redirects to Stage 3
         goto_stage3_r        <= cond_c10 && !c10_seen_r && s3_permit;
         // R9: low current or timer ends charging
         terminate_done_r     <= (cond_c10 && !c10_seen_r && !s3_permit) || (|tmr_term);
         // R13: fault pulses
         timer_fault_r        <= tmr_fault;
      end
   end

endmodule // crt_ctrl

// ===== verilog/crt_done_delay.v
`include "crt_consts.vh"

// ************************************************
// Half-hour delay counter for the done stage
// ************************************************
module crt_done_delay #(
   parameter [35:0] HALFHOUR_CYCLES = `CRT_HALFHOUR_CYC
) (
   input  wire       clk,
   input  wire       rst,
   input  wire       run,
   input  wire [5:0] delay_halfhours,
   output reg        expired_r
);

   reg  [35:0] pre_r;
   reg  [5:0]  halves_r;
   wire        tick;

   assign tick = (pre_r == HALFHOUR_CYCLES - 36'd1);

   // Counting restarts from zero each time the done stage is entered
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_r     <= 36'h0;
         halves_r  <= 6'h00;
         expired_r <= 1'b0;
      end else if (!run) begin
         pre_r     <= 36'h0;
         halves_r  <= 6'h00;
         expired_r <= 1'b0;
      end else begin
         pre_r <= tick ? 36'h0 : pre_r + 36'd1;
         if (tick && halves_r != 6'h3F)
            halves_r <= halves_r + 6'h01;
         // A zero delay never expires
         expired_r <= (delay_halfhours != 6'h00) && (halves_r >= delay_halfhours);
      end
   end

endmodule // crt_done_delay
